// [core/tsp_pkg.sv]
// constants shared by the tone status and program loader block
// assumes a 50 MHz core clock and a 32-bit AXI4-Lite register bus
`default_nettype none
package tsp_pkg;
  // register byte addresses
  localparam logic [7:0]  ADDR_PROG     = 8'hc8;
  localparam logic [7:0]  ADDR_TONE     = 8'hcc;
  localparam logic [7:0]  ADDR_MAIN     = 8'hd0;
  localparam logic [7:0]  ADDR_CTRL     = 8'hd4;
  // control register bits
  localparam int          CTL_RX        = 0;
  localparam int          CTL_TX        = 1;
  localparam int          CTL_SEL_EN    = 2;
  localparam int          CTL_SUB_EN    = 3;
  localparam int          CTL_DCS_EN    = 4;
  localparam int          CTL_DSP_EN    = 5;
  localparam int          CTL_RETAIN    = 6;
  localparam int          CTL_W         = 7;
  // main status bits
  localparam int          ST_PROG       = 0;
  localparam int          ST_DCS        = 10;
  localparam int          ST_SUB        = 11;
  localparam int          ST_SEL        = 13;
  // tone status field codes
  localparam logic [5:0]  SUB_INVALID   = 6'h37;
  localparam logic [4:0]  SEL_UNRECOG   = 5'h0d;
  localparam logic [2:0]  DCS_NORMAL    = 3'h2;
  localparam logic [2:0]  DCS_INVERT    = 3'h3;
  localparam logic [2:0]  DCS_TURNOFF   = 3'h5;
  // programming word layout
  localparam int          PW_FIRST      = 15;
  localparam int          PW_B14        = 14;
  localparam logic [1:0]  BLK_0         = 2'h0;
  localparam logic [1:0]  BLK_1         = 2'h1;
  localparam logic [1:0]  BLK_2         = 2'h2;
  localparam logic [4:0]  B1_TONE_BASE  = 5'h03;
  localparam logic [4:0]  B1_LAST       = 5'h11;
  localparam logic [4:0]  B4_TEST_IDX   = 5'h08;
  localparam int          TONE_CNT      = 15;
  // reset patterns for the frame sync words
  localparam logic [15:0] SYNC_DEFAULT  = 16'hc4d7;
  localparam logic [15:0] DATA_DEFAULT  = 16'hb433;
  // programming action time
  localparam int          PROG_TIME_US  = 250;
  localparam int          CLK_MHZ       = 50;
  localparam int          PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {
    TSP_IDLE  = 2'b00,
    TSP_BUSY  = 2'b01
  } tsp_prog_t;
endpackage
`default_nettype wire

// [core/tsp_tone_mon.sv]
// tone status word: masks detector results and raises change events
// assumes detector results are synchronous levels on the core clock
`default_nettype none
module tsp_tone_mon (
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  input  wire logic [4:0]  sel_idx_in,
  input  wire logic [2:0]  sub_code_in,
  input  wire logic [5:0]  sub_idx_in,
  input  wire logic        sel_en_in,
  input  wire logic        sub_en_in,
  input  wire logic        dcs_en_in,
  input  wire logic        tx_in,
  output logic      [15:0] word_out,
  output logic             ev_sel_out,
  output logic             ev_sub_out,
  output logic             ev_dcs_out
);
  logic [4:0] sel_r, sel_nxt;
  logic [2:0] cod_r, cod_nxt;
  logic [5:0] sub_r, sub_nxt;
  logic       es_r, es_nxt, ec_r, ec_nxt, ed_r, ed_nxt;

  // field masking and change detection
  always_comb begin
    sel_nxt = (sel_en_in && !tx_in) ? sel_idx_in : 5'h00;
    cod_nxt = 3'h0;
    if (dcs_en_in && !tx_in && (sub_code_in == tsp_pkg::DCS_NORMAL ||
        sub_code_in == tsp_pkg::DCS_INVERT || sub_code_in == tsp_pkg::DCS_TURNOFF)) begin
      cod_nxt = sub_code_in;
    end
    sub_nxt = (sub_en_in && !tx_in && cod_nxt == 3'h0) ? sub_idx_in : 6'h00;
    es_nxt = (sel_nxt != sel_r) && !((sel_nxt == 5'h00 && sel_r == tsp_pkg::SEL_UNRECOG) ||
             (sel_r == 5'h00 && sel_nxt == tsp_pkg::SEL_UNRECOG)) && !tx_in;
    ec_nxt = (sub_nxt != sub_r) &&
             !(sub_r == 6'h00 && sub_nxt == tsp_pkg::SUB_INVALID) && !tx_in;
    ed_nxt = (cod_nxt != cod_r) && !tx_in;
  end

  // registered fields and one-cycle events
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_r <= 5'h00;
      cod_r <= 3'h0;
      sub_r <= 6'h00;
      es_r  <= 1'b0;
      ec_r  <= 1'b0;
      ed_r  <= 1'b0;
    end else if (ce_in) begin
      sel_r <= sel_nxt;
      cod_r <= cod_nxt;
      sub_r <= sub_nxt;
      es_r  <= es_nxt;
      ec_r  <= ec_nxt;
      ed_r  <= ed_nxt;
    end
  end

  assign word_out   = {sel_r, cod_r, 2'b00, sub_r};
  assign ev_sel_out = es_r;
  assign ev_sub_out = ec_r;
  assign ev_dcs_out = ed_r;

  tx_zero_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && tx_in |=> word_out == 16'h0000 || !$past(ce_in))
    else $error("tone word not zero in transmit");
  sub_excl_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    word_out[10:8] != 3'h0 |-> word_out[5:0] == 6'h00)
    else $error("subaudio index set while dcs code reported");
  dcs_event_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && !tx_in && cod_nxt != cod_r |=> ev_dcs_out)
    else $error("dcs change gave no event");
  inv_quiet_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && sub_r == 6'h00 && sub_nxt == tsp_pkg::SUB_INVALID |=> !ev_sub_out)
    else $error("event raised on no tone to invalid tone");
endmodule // tsp_tone_mon
`default_nettype wire

// [core/tsp_tone_mem.sv]
// programmable selective-call tone table, one register per entry
// assumes the writer drives one write at a time and clear is a pulse
`default_nettype none
module tsp_tone_mem #(
  parameter int DEPTH = 15,
  parameter int WIDTH = 11
) (
  input  wire logic             core_clk_in,
  input  wire logic             rstn_in,
  input  wire logic             ce_in,
  input  wire logic             clear_in,
  input  wire logic             we_in,
  input  wire logic [3:0]       waddr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  input  wire logic [3:0]       raddr_in,
  output logic      [WIDTH-1:0] rdata_out
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rd_r, rd_nxt;

  // one storage word per tone entry
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    logic [WIDTH-1:0] ent_nxt;
    always_comb begin
      ent_nxt = mem_r[g];
      if (clear_in) ent_nxt = '0;
      else if (we_in && waddr_in == 4'(g)) ent_nxt = wdata_in;
    end
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) mem_r[g] <= '0;
      else if (ce_in) mem_r[g] <= ent_nxt;
    end
  end

  // registered read port
  always_comb begin
    rd_nxt = (32'(raddr_in) < DEPTH) ? mem_r[raddr_in] : '0;
  end
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) rd_r <= '0;
    else if (ce_in) rd_r <= rd_nxt;
  end
  assign rdata_out = rd_r;
endmodule // tsp_tone_mem
`default_nettype wire

// [core/tsp_top.sv]
// tone status and program loader with its AXI4-Lite register slave
// assumes detector levels and the bus are synchronous to core_clk_in
`default_nettype none
// Function
// - status word fields at fixed bit positions
// - no subaudio tone reads index zero
// - foreign subaudio tone reads invalid code
// - index change raises subaudio event, with exception
// - no selective-call tone reads zero
// - selective-call change raises event, with exception
// - dcs and subaudio index mutually exclusive
// - subaudio codes; dcs codes need dcs enable
// - dcs code change raises dcs event
// - dcs loss and recovery raise events
// - disabled detector fields read zero
// - transmit mode zeroes whole status word
// - leaving reset restores defaults unless retained
// - write clears ready; completion sets it
// - words in order from first; blocks any order
// - first bit and block select decoding
// - block one word sequence and tone table
// - block zero loads sync pattern bytes
// - event bits clear on read
module tsp_top #(
  parameter int PROG_CYC = tsp_pkg::PROG_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [4:0]  sel_idx_in,
  input  wire logic [2:0]  sub_code_in,
  input  wire logic [5:0]  sub_idx_in,
  input  wire logic [3:0]  tone_sel_in,
  output logic [10:0]      tone_word_out,
  output logic [15:0]      frame_sync_out,
  output logic [15:0]      frame_sync_inverted_out,
  output logic [15:0]      frame_sync_data_out,
  output logic [11:0]      tx_level_out,
  output logic [11:0]      detect_cfg_out,
  output logic [10:0]      repeat_tone_out,
  output logic             aux_we_out,
  output logic [2:0]       aux_block_out,
  output logic [4:0]       aux_index_out,
  output logic [13:0]      aux_data_out
);
  localparam logic [15:0] PROG_CNT = 16'(PROG_CYC - 1);

  // bus state
  logic        awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, bval_r, bval_nxt;
  logic        awh_r, awh_nxt, wh_r, wh_nxt;
  logic [7:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic        arrdy_r, arrdy_nxt, rval_r, rval_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        wr_go, rd_go, rd_main;
  // register state
  logic [tsp_pkg::CTL_W-1:0] ctl_r, ctl_nxt;
  logic [15:0] st_r, st_nxt;
  logic        dsp_start, prog_wr;
  // loader state
  tsp_pkg::tsp_prog_t ps_r, ps_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [2:0]  blk_r, blk_nxt;
  logic [4:0]  idx_r, idx_nxt;
  logic [15:0] sync_r, sync_nxt, data_r, data_nxt;
  logic [11:0] txl_r, txl_nxt, det_r, det_nxt;
  logic [10:0] rep_r, rep_nxt;
  logic        axw_r, axw_nxt;
  logic [2:0]  axb_r, axb_nxt;
  logic [4:0]  axi_r, axi_nxt;
  logic [13:0] axd_r, axd_nxt;
  logic        tw_we, defaults;
  logic [2:0]  wblk;
  logic [4:0]  widx;
  logic [15:0] tone_word;
  logic        ev_sel, ev_sub, ev_dcs;

  // write channel: address and data taken in either order
  always_comb begin
    awh_nxt = awh_r;
    wh_nxt  = wh_r;
    awa_nxt = awa_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    bval_nxt = bval_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && awrdy_r) begin
      awh_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wrdy_r) begin
      wh_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    wr_go = awh_r && wh_r && !bval_r;
    if (wr_go) begin
      awh_nxt  = 1'b0;
      wh_nxt   = 1'b0;
      bval_nxt = 1'b1;
      if (awa_r == tsp_pkg::ADDR_PROG || awa_r == tsp_pkg::ADDR_CTRL ||
          awa_r == tsp_pkg::ADDR_TONE || awa_r == tsp_pkg::ADDR_MAIN) begin
        bresp_nxt = tsp_pkg::RESP_OKAY;
      end else begin
        bresp_nxt = tsp_pkg::RESP_SLVERR;
      end
    end else if (bval_r && s_axi_bready) begin
      bval_nxt = 1'b0;
    end
    awrdy_nxt = !awh_nxt && !bval_nxt;
    wrdy_nxt  = !wh_nxt && !bval_nxt;
  end

  // read channel: one read at a time, data one cycle after address
  always_comb begin
    arrdy_nxt = arrdy_r;
    rval_nxt  = rval_r;
    rd_nxt    = rd_r;
    rresp_nxt = rresp_r;
    rd_go     = s_axi_arvalid && arrdy_r;
    rd_main   = 1'b0;
    if (rd_go) begin
      arrdy_nxt = 1'b0;
      rval_nxt  = 1'b1;
      rresp_nxt = tsp_pkg::RESP_OKAY;
      if (s_axi_araddr == tsp_pkg::ADDR_TONE) begin
        rd_nxt = {16'h0000, tone_word};
      end else if (s_axi_araddr == tsp_pkg::ADDR_MAIN) begin
        rd_nxt  = {16'h0000, st_r};
        rd_main = 1'b1;
      end else if (s_axi_araddr == tsp_pkg::ADDR_CTRL) begin
        rd_nxt = {25'h0000000, ctl_r};
      end else if (s_axi_araddr == tsp_pkg::ADDR_PROG) begin
        rd_nxt = 32'h00000000;
      end else begin
        rd_nxt    = 32'h00000000;
        rresp_nxt = tsp_pkg::RESP_SLVERR;
      end
    end else if (rval_r && s_axi_rready) begin
      rval_nxt  = 1'b0;
      arrdy_nxt = 1'b1;
    end
  end

  // control register and main status word
  always_comb begin
    ctl_nxt   = ctl_r;
    dsp_start = 1'b0;
    if (wr_go && awa_r == tsp_pkg::ADDR_CTRL && ws_r[0]) begin
      ctl_nxt   = wd_r[tsp_pkg::CTL_W-1:0];
      dsp_start = wd_r[tsp_pkg::CTL_DSP_EN] && !ctl_r[tsp_pkg::CTL_DSP_EN];
    end
    prog_wr = wr_go && awa_r == tsp_pkg::ADDR_PROG && st_r[tsp_pkg::ST_PROG];
    st_nxt = st_r;
    if (rd_main) begin
      st_nxt[15:1] = 15'h0000;
    end
    // events win over the clear of the same cycle
    if (ev_sel) st_nxt[tsp_pkg::ST_SEL] = 1'b1;
    if (ev_sub) st_nxt[tsp_pkg::ST_SUB] = 1'b1;
    if (ev_dcs) st_nxt[tsp_pkg::ST_DCS] = 1'b1;
    if (dsp_start || (ps_r == tsp_pkg::TSP_BUSY && cnt_r == PROG_CNT)) begin
      st_nxt[tsp_pkg::ST_PROG] = 1'b1;
    end else if (prog_wr) begin
      st_nxt[tsp_pkg::ST_PROG] = 1'b0;
    end
  end

  // programming word decode and block sequencing
  always_comb begin
    ps_nxt  = ps_r;
    cnt_nxt = cnt_r;
    blk_nxt = blk_r;
    idx_nxt = idx_r;
    sync_nxt = sync_r;
    data_nxt = data_r;
    txl_nxt = txl_r;
    det_nxt = det_r;
    rep_nxt = rep_r;
    axw_nxt = 1'b0;
    axb_nxt = axb_r;
    axi_nxt = axi_r;
    axd_nxt = axd_r;
    tw_we   = 1'b0;
    defaults = dsp_start && !ctl_r[tsp_pkg::CTL_RETAIN];
    wblk = wd_r[tsp_pkg::PW_B14] ? {1'b0, wd_r[13:12]} : 3'h4;
    widx = wd_r[tsp_pkg::PW_FIRST] ? 5'h00 : idx_r + 5'h01;
    if (ps_r == tsp_pkg::TSP_BUSY) begin
      cnt_nxt = cnt_r + 16'h0001;
      if (cnt_r == PROG_CNT) ps_nxt = tsp_pkg::TSP_IDLE;
    end
    if (defaults) begin
      ps_nxt   = tsp_pkg::TSP_IDLE;
      sync_nxt = tsp_pkg::SYNC_DEFAULT;
      data_nxt = tsp_pkg::DATA_DEFAULT;
      txl_nxt  = 12'h000;
      det_nxt  = 12'h000;
      rep_nxt  = 11'h000;
      blk_nxt  = 3'h0;
      idx_nxt  = 5'h00;
    end else if (prog_wr) begin
      ps_nxt  = tsp_pkg::TSP_BUSY;
      cnt_nxt = 16'h0000;
      // later words only count when they follow the open block
      if (wd_r[tsp_pkg::PW_FIRST] || wblk == blk_r) begin
        blk_nxt = wblk;
        idx_nxt = widx;
        if (wblk == {1'b0, tsp_pkg::BLK_0}) begin
          case (widx[1:0])
            2'b00: sync_nxt[7:0]  = wd_r[7:0];
            2'b01: sync_nxt[15:8] = wd_r[7:0];
            2'b10: data_nxt[7:0]  = wd_r[7:0];
            default: data_nxt[15:8] = wd_r[7:0];
          endcase
        end else if (wblk == {1'b0, tsp_pkg::BLK_1}) begin
          if (widx == 5'h00) txl_nxt = wd_r[11:0];
          else if (widx == 5'h01) det_nxt = wd_r[11:0];
          else if (widx == 5'h02) rep_nxt = wd_r[10:0];
          else if (widx <= tsp_pkg::B1_LAST) tw_we = 1'b1;
        end else if (wblk == {1'b0, tsp_pkg::BLK_2} ||
                     (wblk == 3'h4 && widx != tsp_pkg::B4_TEST_IDX)) begin
          axw_nxt = 1'b1;
          axb_nxt = wblk;
          axi_nxt = widx;
          axd_nxt = (wblk == 3'h4) ? wd_r[13:0] : {2'b00, wd_r[11:0]};
        end
      end
    end
  end

  // registers of every group
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      awrdy_r <= 1'b1;
      wrdy_r  <= 1'b1;
      bval_r  <= 1'b0;
      awh_r   <= 1'b0;
      wh_r    <= 1'b0;
      awa_r   <= 8'h00;
      wd_r    <= 32'h00000000;
      ws_r    <= 4'h0;
      bresp_r <= tsp_pkg::RESP_OKAY;
      arrdy_r <= 1'b1;
      rval_r  <= 1'b0;
      rd_r    <= 32'h00000000;
      rresp_r <= tsp_pkg::RESP_OKAY;
      ctl_r   <= '0;
      st_r    <= 16'h0001;
      ps_r    <= tsp_pkg::TSP_IDLE;
      cnt_r   <= 16'h0000;
      blk_r   <= 3'h0;
      idx_r   <= 5'h00;
      sync_r  <= tsp_pkg::SYNC_DEFAULT;
      data_r  <= tsp_pkg::DATA_DEFAULT;
      txl_r   <= 12'h000;
      det_r   <= 12'h000;
      rep_r   <= 11'h000;
      axw_r   <= 1'b0;
      axb_r   <= 3'h0;
      axi_r   <= 5'h00;
      axd_r   <= 14'h0000;
    end else if (ce_in) begin
      awrdy_r <= awrdy_nxt;
      wrdy_r  <= wrdy_nxt;
      bval_r  <= bval_nxt;
      awh_r   <= awh_nxt;
      wh_r    <= wh_nxt;
      awa_r   <= awa_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      bresp_r <= bresp_nxt;
      arrdy_r <= arrdy_nxt;
      rval_r  <= rval_nxt;
      rd_r    <= rd_nxt;
      rresp_r <= rresp_nxt;
      ctl_r   <= ctl_nxt;
      st_r    <= st_nxt;
      ps_r    <= ps_nxt;
      cnt_r   <= cnt_nxt;
      blk_r   <= blk_nxt;
      idx_r   <= idx_nxt;
      sync_r  <= sync_nxt;
      data_r  <= data_nxt;
      txl_r   <= txl_nxt;
      det_r   <= det_nxt;
      rep_r   <= rep_nxt;
      axw_r   <= axw_nxt;
      axb_r   <= axb_nxt;
      axi_r   <= axi_nxt;
      axd_r   <= axd_nxt;
    end
  end

  tsp_tone_mon u_mon (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .ce_in       (ce_in),
    .sel_idx_in  (sel_idx_in),
    .sub_code_in (sub_code_in),
    .sub_idx_in  (sub_idx_in),
    .sel_en_in   (ctl_r[tsp_pkg::CTL_SEL_EN]),
    .sub_en_in   (ctl_r[tsp_pkg::CTL_SUB_EN]),
    .dcs_en_in   (ctl_r[tsp_pkg::CTL_DCS_EN]),
    .tx_in       (ctl_r[tsp_pkg::CTL_TX]),
    .word_out    (tone_word),
    .ev_sel_out  (ev_sel),
    .ev_sub_out  (ev_sub),
    .ev_dcs_out  (ev_dcs)
  );

  tsp_tone_mem #(.DEPTH(tsp_pkg::TONE_CNT), .WIDTH(11)) u_mem (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .ce_in       (ce_in),
    .clear_in    (defaults),
    .we_in       (tw_we),
    .waddr_in    (4'(idx_nxt - tsp_pkg::B1_TONE_BASE)),
    .wdata_in    (wd_r[10:0]),
    .raddr_in    (tone_sel_in),
    .rdata_out   (tone_word_out)
  );

  // outputs straight from flip-flops, frame_sync_inverted_out through an inverter
  assign s_axi_awready = awrdy_r;
  assign s_axi_wready  = wrdy_r;
  assign s_axi_bvalid  = bval_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arrdy_r;
  assign s_axi_rvalid  = rval_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rresp_r;
  assign frame_sync_out          = sync_r;
  assign frame_sync_inverted_out = ~sync_r;
  assign frame_sync_data_out     = data_r;
  assign tx_level_out    = txl_r;
  assign detect_cfg_out  = det_r;
  assign repeat_tone_out = rep_r;
  assign aux_we_out    = axw_r;
  assign aux_block_out = axb_r;
  assign aux_index_out = axi_r;
  assign aux_data_out  = axd_r;

  flag_clear_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && prog_wr && !dsp_start |=> !st_r[tsp_pkg::ST_PROG])
    else $error("ready flag not cleared by program write");
  flag_back_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ps_r == tsp_pkg::TSP_BUSY && cnt_r > PROG_CNT |-> 1'b0)
    else $error("programming action overran its time");
  flag_set_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && ps_r == tsp_pkg::TSP_BUSY && cnt_r == PROG_CNT |=> st_r[tsp_pkg::ST_PROG])
    else $error("ready flag not restored");
  read_clear_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && rd_main && !ev_sel && !ev_sub && !ev_dcs |=> st_r[15:1] == 15'h0000)
    else $error("event bits not cleared on read");
  set_wins_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && ev_sel |=> st_r[tsp_pkg::ST_SEL])
    else $error("selective-call event lost");
  restore_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && defaults |=> sync_r == tsp_pkg::SYNC_DEFAULT && st_r[tsp_pkg::ST_PROG])
    else $error("defaults not restored on processing start");
  inverse_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    frame_sync_inverted_out == ~frame_sync_out)
    else $error("inverse sync pattern mismatch");
  ro_zero_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ce_in && rd_go && s_axi_araddr == tsp_pkg::ADDR_TONE |=> s_axi_rdata[7:6] == 2'b00)
    else $error("reserved tone status bits not zero");
  prog_cov: cover property (@(posedge core_clk_in) disable iff (!rstn_in) prog_wr);
  tone_cov: cover property (@(posedge core_clk_in) disable iff (!rstn_in) tw_we);
  ev_cov: cover property (@(posedge core_clk_in) disable iff (!rstn_in) ev_dcs ##1 rd_main);
endmodule // tsp_top
`default_nettype wire

// [dv/tsp_host.sv]
// host model: AXI4-Lite master with write, read and program tasks
// assumes the bench bounds every wait with its own cycle ceiling
`default_nettype none
module tsp_host (
  input  wire logic        core_clk_in,
  output logic      [7:0]  s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [7:0]  s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus idle at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // write: each channel dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic b;
    b = 1'b0;
    @(posedge core_clk_in);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b) begin
      @(posedge core_clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask
  // read: data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic b;
    b = 1'b0;
    @(posedge core_clk_in);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!b) begin
      @(posedge core_clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      {b, v, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      if (b) s_axi_rready <= 1'b0;
    end
  endtask
  // program word: wait for the ready flag, callers keep word order
  task automatic prog(input logic [15:0] w);
    logic [31:0] s;
    logic [1:0]  r;
    s = '0;
    while (s[0] !== 1'b1) rd(tsp_pkg::ADDR_MAIN, s, r);
    wr(tsp_pkg::ADDR_PROG, {16'h0, w});
  endtask
endmodule // tsp_host
`default_nettype wire

// [dv/tone_status_and_program_loader_tb.sv]
// bench for the tone status and program loader
// assumes tsp_pkg, tsp_top and tsp_host are compiled first
`default_nettype none
module tone_status_and_program_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 20; // short programming action
  logic core_clk_in, rstn_in, ce_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic aux_we_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] sub_code_in, aux_block_out;
  logic [3:0] s_axi_wstrb, tone_sel_in;
  logic [4:0] sel_idx_in, aux_index_out;
  logic [5:0] sub_idx_in;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [10:0] tone_word_out, repeat_tone_out;
  logic [11:0] tx_level_out, detect_cfg_out;
  logic [13:0] aux_data_out;
  logic [15:0] frame_sync_out, frame_sync_inverted_out, frame_sync_data_out;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  // control, raw detector word laid out as the status word, expected word
  logic [39:0] rows [8] = '{40'h3c_1805_1805, 40'h3c_0205_0200, 40'h3c_0300_0300,
    40'h3c_0500_0500, 40'h2c_0200_0000, 40'h38_1837_0037, 40'h3e_1805_0000, 40'h3c_0000_0000};
  tsp_top #(.PROG_CYC(PC)) i_dut (.*);
  tsp_host i_host (.*);
  always #10 core_clk_in = ~core_clk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // program one word and let the action finish
  task automatic pw(input logic [15:0] w);
    i_host.prog(w);
    repeat (PC + 4) @(posedge core_clk_in);
  endtask
  // cycle ceiling against a hung handshake
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // reset, status table, events, programming, defaults, unmapped read
  initial begin
    {core_clk_in, rstn_in, ce_in, tone_sel_in} = 7'h10;
    {sel_idx_in, sub_code_in, sub_idx_in} = '0;
    repeat (10) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    i_host.rd(tsp_pkg::ADDR_MAIN, d, r);
    chk(d, 32'h1);
    chk({16'h0, frame_sync_data_out}, 32'hb433);
    foreach (rows[n]) begin
      i_host.wr(tsp_pkg::ADDR_CTRL, {24'h0, rows[n][39:32]});
      {sel_idx_in, sub_code_in, sub_idx_in} <= {rows[n][31:24], rows[n][21:16]};
      repeat (4) @(posedge core_clk_in);
      i_host.rd(tsp_pkg::ADDR_TONE, d, r);
      chk(d, {16'h0, rows[n][15:0]});
    end
    i_host.rd(tsp_pkg::ADDR_MAIN, d, r);
    {sel_idx_in, sub_idx_in} <= {tsp_pkg::SEL_UNRECOG, tsp_pkg::SUB_INVALID};
    repeat (5) @(posedge core_clk_in);
    i_host.rd(tsp_pkg::ADDR_MAIN, d, r);
    chk(d, 32'h1);
    {sel_idx_in, sub_code_in} <= {5'h04, tsp_pkg::DCS_NORMAL};
    repeat (5) @(posedge core_clk_in);
    i_host.rd(tsp_pkg::ADDR_MAIN, d, r);
    chk(d, 32'h2c01);
    i_host.rd(tsp_pkg::ADDR_TONE, d, r);
    chk(d, 32'h2200);
    i_host.rd(tsp_pkg::ADDR_MAIN, d, r);
    chk(d, 32'h1);
    i_host.prog(16'hc0aa);
    i_host.rd(tsp_pkg::ADDR_MAIN, d, r);
    chk(d, 32'h0);
    pw(16'h40bb);
    i_host.prog(16'h40bb);
    i_host.wr(tsp_pkg::ADDR_PROG, 32'h40cc);
    repeat (PC + 4) @(posedge core_clk_in);
    chk({frame_sync_out, frame_sync_inverted_out}, 32'hbbaa4455);
    chk({16'h0, frame_sync_data_out}, 32'hb4bb);
    pw(16'hd456);
    chk({20'h0, tx_level_out}, 32'h456);
    pw(16'h5012);
    chk({20'h0, detect_cfg_out}, 32'h012);
    pw(16'h5345);
    chk({21'h0, repeat_tone_out}, 32'h345);
    pw(16'h5067);
    chk({21'h0, tone_word_out}, 32'h067);
    pw(16'he123);
    chk({15'h0, aux_block_out, aux_data_out}, 32'h8123);
    pw(16'h8abc);
    chk({15'h0, aux_block_out, aux_data_out}, 32'h10abc);
    i_host.wr(tsp_pkg::ADDR_CTRL, 32'h0);
    i_host.wr(tsp_pkg::ADDR_CTRL, 32'h20);
    repeat (2) @(posedge core_clk_in);
    chk({frame_sync_out, 4'h0, tx_level_out}, 32'hc4d70000);
    chk({21'h0, tone_word_out}, 32'h0);
    i_host.rd(8'h10, d, r);
    chk({d[29:0], r}, {30'h0, tsp_pkg::RESP_SLVERR});
    wrap_up();
  end
endmodule // tone_status_and_program_loader_tb
`default_nettype wire
